/* File: logic/exec_params.svh */
/*
 * Constants for the swap / supervisor call / coprocessor data execution block.
 * Assumes inclusion by bare name from the design module and the bench.
 */
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_INSTR 6'h00
`define OFS_STATUS_WORD 6'h04
`define OFS_SAVED_STATUS 6'h08
`define OFS_LINK 6'h0c
`define OFS_PC 6'h10
`define OFS_SWAP_BASE 6'h14
`define OFS_SWAP_SOURCE 6'h18
`define OFS_SWAP_RESULT 6'h1c
`define OFS_EXEC_STATUS 6'h20
`define OFS_CONTROL 6'h24

// ----------------------------------------
// Fields, vectors and reset values
// ----------------------------------------
`define MODE_LSB 0
`define MODE_MSB 4
`define MODE_SUPERVISOR 5'h13
`define MODE_ABORT 5'h17
`define STATUS_RESET 32'h0000_0013
`define SUPERVISOR_VECTOR 32'h0000_0008
`define ABORT_VECTOR 32'h0000_0010
`define PC_STEP 32'h0000_0004
`define EXEC_ABORT_BIT 1
`define CONTROL_BIG_ENDIAN_BIT 0

// ----------------------------------------
// Instruction decode patterns
// ----------------------------------------
`define SWAP_MASK 32'h0fb0_0ff0
`define SWAP_MATCH 32'h0100_0090
`define RETURN_MASK 32'h0fff_ffff
`define RETURN_MATCH 32'h01b0_f00e
`define SVC_CLASS 4'hf
`define CDP_CLASS 4'he
`define SWAP_BYTE_BIT 22
`define CDP_BIT4 4
`endif

/* File: logic/exec_pkg.sv */
/*
 * Types shared by the execution block.
 * Assumes exec_params.svh is on the include path.
 */
package exec_pkg;
   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_SWP_RD = 4'h1,
      ST_SWP_WR = 4'h2,
      ST_SWP_INT = 4'h3,
      ST_SWP_SEQ = 4'h4,
      ST_SVC_S1 = 4'h5,
      ST_SVC_S2 = 4'h6,
      ST_SVC_N = 4'h7,
      ST_CDP_ISSUE = 4'h8,
      ST_CDP_SEQ = 4'h9
   } exec_state_type;

   // Memory request toward the memory manager
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic read;
      logic write;
      logic byte_sel;
      logic lock;
   } mem_req_type;
endpackage : exec_pkg

/* File: logic/cond_check.sv */
/*
 * Condition field evaluator against the N Z C V flags.
 * Assumes flags ordered N, Z, C, V from bit 3 down; purely combinational.
 */
module cond_check (
   input wire logic [3:0] cond,
   input wire logic [3:0] flags,
   output logic pass
);
   wire n = flags[3];
   wire z = flags[2];
   wire c = flags[1];
   wire v = flags[0];
   logic base;

   // ----------------------------------------
   // Even codes test, odd codes invert
   // ----------------------------------------
   always_comb begin
      case (cond[3:1])
         3'h0: base = z;
         3'h1: base = c;
         3'h2: base = n;
         3'h3: base = v;
         3'h4: base = c & ~z;
         3'h5: base = (n == v);
         3'h6: base = ~z & (n == v);
         default: base = 1'b1;
      endcase
   end

   // Code 4'hf is treated as never, matching the inverted always slot
   assign pass = base ^ cond[0];
endmodule : cond_check

/* File: logic/swap_swi_coproc_data_exec.sv */
/*
 * Execution sequencer for atomic swap, supervisor call and coprocessor data
 * operations, with an Avalon-MM slave for its registers.
 * Assumes a memory manager that answers each access with mem_ready and may
 * raise mem_abort alongside it, and coprocessors that hold cp_busy until they
 * accept an issued operation. One clock, asynchronous active-low reset.
 */
`include "exec_params.svh"

module swap_swi_coproc_data_exec (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output exec_pkg::mem_req_type mem_req,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ready,
   input wire logic mem_abort,
   output logic [31:0] cp_instr,
   output logic cp_valid,
   input wire logic cp_busy,
   output logic irq_inhibit
);
   exec_pkg::exec_state_type state_reg;
   exec_pkg::mem_req_type mem_req_reg;
   logic ack_reg, waitrequest_reg;
   logic [31:0] readdata_reg;
   logic [31:0] instr_reg, status_reg, saved_reg, link_reg, pc_reg;
   logic [31:0] base_reg, source_reg, result_reg, read_hold_reg;
   logic [31:0] cp_instr_reg;
   logic cp_valid_reg, irq_inhibit_reg;
   logic abort_seen_reg, abort_sticky_reg, skipped_reg, big_endian_reg;
   logic [7:0] busy_count_reg;
   logic cond_pass;

   // ----------------------------------------
   // Byte extraction by lane and endianness
   // ----------------------------------------
   function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] a, input logic big);
      logic [1:0] lane;
      lane = big ? ~a : a;
      pick_byte = w[8*lane +: 8];
   endfunction : pick_byte

   // Bus decode; writes wait while an instruction is in flight
   wire busy = (state_reg != exec_pkg::ST_IDLE);
   wire bus_take = (avs_read | (avs_write & ~busy)) & ~ack_reg;
   wire bus_wr_go = avs_write & ack_reg;
   wire issue = bus_wr_go & (avs_address == `OFS_INSTR);
   wire [31:0] iw = avs_writedata;
   wire is_swap = ((iw & `SWAP_MASK) == `SWAP_MATCH);
   wire is_return = ((iw & `RETURN_MASK) == `RETURN_MATCH);
   wire is_svc = (iw[27:24] == `SVC_CLASS);
   wire is_cdp = (iw[27:24] == `CDP_CLASS) & ~iw[`CDP_BIT4];
   wire swap_byte = instr_reg[`SWAP_BYTE_BIT];
   wire [7:0] rd_byte = pick_byte(mem_rdata, mem_req_reg.addr[1:0], big_endian_reg);
   wire [31:0] rd_value = swap_byte ? {24'h0, rd_byte} : mem_rdata;
   wire [31:0] wr_value = swap_byte ? {4{source_reg[7:0]}} : source_reg;
   wire [31:0] exec_status = {16'h0, busy_count_reg, 5'h0, skipped_reg, abort_sticky_reg, busy};

   // Condition evaluated on the incoming word before anything is started
   cond_check cond_unit (
      .cond(iw[31:28]),
      .flags(status_reg[31:28]),
      .pass(cond_pass)
   );

   // Read data selection; unmapped offsets read as zero
   logic [31:0] rd_mux;
   always_comb begin
      case (avs_address)
         `OFS_INSTR: rd_mux = instr_reg;
         `OFS_STATUS_WORD: rd_mux = status_reg;
         `OFS_SAVED_STATUS: rd_mux = saved_reg;
         `OFS_LINK: rd_mux = link_reg;
         `OFS_PC: rd_mux = pc_reg;
         `OFS_SWAP_BASE: rd_mux = base_reg;
         `OFS_SWAP_SOURCE: rd_mux = source_reg;
         `OFS_SWAP_RESULT: rd_mux = result_reg;
         `OFS_EXEC_STATUS: rd_mux = exec_status;
         `OFS_CONTROL: rd_mux = {31'h0, big_endian_reg};
         default: rd_mux = 32'h0;
      endcase
   end

   // ----------------------------------------
   // Avalon slave: one wait state on reads and on writes while idle
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
         waitrequest_reg <= 1'b1;
         readdata_reg <= 32'h0;
      end else begin
         ack_reg <= bus_take;
         waitrequest_reg <= ~bus_take; // Own flop so the pin needs no inverter
         if (bus_take) begin
            readdata_reg <= rd_mux;
         end
      end
   end

   // Plain software registers, written only while idle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         base_reg <= 32'h0;
         source_reg <= 32'h0;
         big_endian_reg <= 1'b0;
         instr_reg <= 32'h0;
      end else if (bus_wr_go) begin
         if (avs_address == `OFS_SWAP_BASE) base_reg <= avs_writedata;
         if (avs_address == `OFS_SWAP_SOURCE) source_reg <= avs_writedata;
         if (avs_address == `OFS_CONTROL) big_endian_reg <= avs_writedata[`CONTROL_BIG_ENDIAN_BIT];
         if (issue) instr_reg <= avs_writedata;
      end
   end

   // ----------------------------------------
   // Sequencer and memory side
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= exec_pkg::ST_IDLE;
         mem_req_reg <= '0;
         read_hold_reg <= 32'h0;
         abort_seen_reg <= 1'b0;
         irq_inhibit_reg <= 1'b0;
         cp_instr_reg <= 32'h0;
         cp_valid_reg <= 1'b0;
         busy_count_reg <= 8'h0;
         skipped_reg <= 1'b0;
      end else begin
         case (state_reg)
            exec_pkg::ST_IDLE: begin
               if (issue) begin
                  skipped_reg <= ~cond_pass;
                  if (cond_pass && is_swap) begin
                     mem_req_reg.addr <= base_reg;
                     mem_req_reg.read <= 1'b1;
                     mem_req_reg.lock <= 1'b1;
                     mem_req_reg.byte_sel <= iw[`SWAP_BYTE_BIT];
                     abort_seen_reg <= 1'b0;
                     irq_inhibit_reg <= 1'b1;
                     state_reg <= exec_pkg::ST_SWP_RD;
                  end else if (cond_pass && is_svc) begin
                     state_reg <= exec_pkg::ST_SVC_S1;
                  end else if (cond_pass && is_cdp) begin
                     cp_instr_reg <= iw;
                     cp_valid_reg <= 1'b1;
                     busy_count_reg <= 8'h0;
                     state_reg <= exec_pkg::ST_CDP_ISSUE;
                  end
               end
            end
            exec_pkg::ST_SWP_RD: begin
               if (mem_ready) begin
                  read_hold_reg <= rd_value;
                  abort_seen_reg <= mem_abort;
                  mem_req_reg.read <= 1'b0;
                  mem_req_reg.write <= 1'b1;
                  mem_req_reg.wdata <= wr_value;
                  state_reg <= exec_pkg::ST_SWP_WR;
               end
            end
            exec_pkg::ST_SWP_WR: begin
               if (mem_ready) begin
                  abort_seen_reg <= abort_seen_reg | mem_abort;
                  mem_req_reg.write <= 1'b0;
                  mem_req_reg.lock <= 1'b0;
                  state_reg <= exec_pkg::ST_SWP_INT;
               end
            end
            exec_pkg::ST_SWP_INT: begin
               irq_inhibit_reg <= 1'b0;
               state_reg <= exec_pkg::ST_SWP_SEQ;
            end
            exec_pkg::ST_SVC_S1: state_reg <= exec_pkg::ST_SVC_S2;
            exec_pkg::ST_SVC_S2: state_reg <= exec_pkg::ST_SVC_N;
            exec_pkg::ST_CDP_ISSUE: begin
               if (cp_busy) begin
                  busy_count_reg <= busy_count_reg + 8'h1;
               end else begin
                  cp_valid_reg <= 1'b0;
                  state_reg <= exec_pkg::ST_CDP_SEQ;
               end
            end
            default: state_reg <= exec_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Architectural state: pc, status words, link, result
   // ----------------------------------------
   // Result is only loaded after both accesses, so a register used as
   // source and destination gives the old memory value back intact.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_reg <= 32'h0;
         status_reg <= `STATUS_RESET;
         saved_reg <= 32'h0;
         link_reg <= 32'h0;
         result_reg <= 32'h0;
         abort_sticky_reg <= 1'b0;
      end else begin
         if (bus_wr_go && avs_address == `OFS_PC) pc_reg <= avs_writedata;
         if (bus_wr_go && avs_address == `OFS_STATUS_WORD) status_reg <= avs_writedata;
         if (bus_wr_go && avs_address == `OFS_SAVED_STATUS) saved_reg <= avs_writedata;
         if (bus_wr_go && avs_address == `OFS_LINK) link_reg <= avs_writedata;
         // Write one to clear; a new abort in the same cycle wins
         if (bus_wr_go && avs_address == `OFS_EXEC_STATUS && avs_writedata[`EXEC_ABORT_BIT])
            abort_sticky_reg <= 1'b0;
         if (issue && !cond_pass) pc_reg <= pc_reg + `PC_STEP;
         if (issue && cond_pass && is_return) begin
            pc_reg <= link_reg;
            status_reg <= saved_reg;
         end
         if (state_reg == exec_pkg::ST_SWP_INT) begin
            if (abort_seen_reg) begin
               abort_sticky_reg <= 1'b1;
               saved_reg <= status_reg;
               link_reg <= pc_reg + `PC_STEP;
               status_reg[`MODE_MSB:`MODE_LSB] <= `MODE_ABORT;
               pc_reg <= `ABORT_VECTOR;
            end else begin
               result_reg <= read_hold_reg;
               pc_reg <= pc_reg + `PC_STEP;
            end
         end
         if (state_reg == exec_pkg::ST_SVC_N) begin
            saved_reg <= status_reg;
            status_reg[`MODE_MSB:`MODE_LSB] <= `MODE_SUPERVISOR;
            link_reg <= pc_reg + `PC_STEP;
            pc_reg <= `SUPERVISOR_VECTOR;
         end
         if (state_reg == exec_pkg::ST_CDP_SEQ) pc_reg <= pc_reg + `PC_STEP;
      end
   end

   // Outputs straight from flops
   assign avs_readdata = readdata_reg;
   assign avs_waitrequest = waitrequest_reg;
   assign mem_req = mem_req_reg;
   assign cp_instr = cp_instr_reg;
   assign cp_valid = cp_valid_reg;
   assign irq_inhibit = irq_inhibit_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking chk_clk @(posedge clk); endclocking
   default disable iff (!rst_b);

   lock_read_a: assert property (mem_req_reg.read |-> mem_req_reg.lock)
      else $error("swap read without lock");
   lock_write_a: assert property (mem_req_reg.write |-> mem_req_reg.lock && irq_inhibit_reg)
      else $error("swap write without lock or inhibit");
   lock_release_a: assert property (state_reg == exec_pkg::ST_SWP_WR && mem_ready |=> !mem_req_reg.lock)
      else $error("lock held after write completed");
   read_then_write_a: assert property (state_reg == exec_pkg::ST_SWP_RD && mem_ready
      |=> mem_req_reg.write && !mem_req_reg.read && $stable(mem_req_reg.addr))
      else $error("swap write did not follow read");
   swap_tail_a: assert property (state_reg == exec_pkg::ST_SWP_WR && mem_ready
      |=> state_reg == exec_pkg::ST_SWP_INT ##1 state_reg == exec_pkg::ST_SWP_SEQ
      ##1 state_reg == exec_pkg::ST_IDLE)
      else $error("swap tail length wrong");
   svc_entry_a: assert property (issue && cond_pass && is_svc
      |=> ##3 pc_reg == `SUPERVISOR_VECTOR && status_reg[`MODE_MSB:`MODE_LSB] == `MODE_SUPERVISOR)
      else $error("supervisor entry not after three cycles");
   skip_a: assert property (issue && !cond_pass |=> state_reg == exec_pkg::ST_IDLE && skipped_reg)
      else $error("failed condition still executed");
   abort_trap_a: assert property (state_reg == exec_pkg::ST_SWP_INT && abort_seen_reg
      |=> pc_reg == `ABORT_VECTOR && abort_sticky_reg)
      else $error("abort trap not taken");
   cdp_release_a: assert property (state_reg == exec_pkg::ST_CDP_ISSUE && !cp_busy
      |=> !cp_valid_reg ##1 state_reg == exec_pkg::ST_IDLE)
      else $error("coprocessor issue not released");
   return_a: assert property (issue && cond_pass && is_return
      |=> pc_reg == $past(link_reg) && status_reg == $past(saved_reg))
      else $error("return did not restore state");
endmodule : swap_swi_coproc_data_exec

/* File: dv/mem_cp_model.sv */
/*
 * Far-side model: memory manager answering reads with mem_init, and one attached coprocessor.
 * Assumes the bench sets its knobs only while no instruction is in flight.
 */
module mem_cp_model #(
   parameter logic [3:0] CP_ID = 4'h4
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire exec_pkg::mem_req_type mem_req,
   output logic [31:0] mem_rdata,
   output logic mem_ready,
   output logic mem_abort,
   input wire logic cp_valid,
   input wire logic [31:0] cp_instr,
   output logic cp_busy,
   input wire logic irq_inhibit,
   input wire logic [31:0] mem_init,
   input wire logic [3:0] delay,
   input wire logic [1:0] abort_mode,
   input wire logic [7:0] busy_n,
   output logic [31:0] wr_data,
   output logic [31:0] wr_addr,
   output logic [7:0] acc_count,
   output logic [7:0] cp_count,
   output logic [7:0] lock_err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_reg;
   logic [7:0] cp_edges;
   wire active = mem_req.read | mem_req.write;
   wire cp_match = cp_instr[11:8] == CP_ID;
   // Busy as a level so the very first issue edge already sees it
   assign cp_busy = cp_valid && cp_match && (cp_edges < busy_n);

   // ----------------------------------------
   // Memory answer; released data toggles so a stale value cannot pass
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_ready <= 1'b0;
         mem_abort <= 1'b0;
         mem_rdata <= 32'h0;
         wait_reg <= 4'h0;
         wr_data <= 32'h0;
         wr_addr <= 32'h0;
         acc_count <= 8'h0;
         cp_count <= 8'h0;
         lock_err <= 8'h0;
         cp_edges <= 8'h0;
      end else begin
         mem_ready <= 1'b0;
         mem_abort <= 1'b0;
         mem_rdata <= ~mem_rdata;
         // Ownership never leaves the processor: no other master is served
         if (active && !mem_ready) begin
            if (wait_reg == delay) begin
               mem_ready <= 1'b1;
               wait_reg <= 4'h0;
               acc_count <= acc_count + 8'h1;
               mem_abort <= mem_req.read ? abort_mode[0] : abort_mode[1];
               if (mem_req.read) begin
                  mem_rdata <= mem_init;
               end else begin
                  wr_data <= mem_req.wdata;
                  wr_addr <= mem_req.addr;
               end
            end else begin
               wait_reg <= wait_reg + 4'h1;
            end
         end
         // Any access seen unlocked or interruptible is counted
         if (active && !(mem_req.lock && irq_inhibit)) begin
            lock_err <= lock_err + 8'h1;
         end
         cp_edges <= cp_valid ? cp_edges + 8'h1 : 8'h0;
         if (cp_valid && cp_match && !cp_busy) begin
            cp_count <= cp_count + 8'h1;
         end
      end
   end
endmodule : mem_cp_model

/* File: dv/tb_swap_swi_coproc_data_exec.sv */
/*
 * Self-checking bench for the execution block over its Avalon-MM registers.
 * Assumes the far-side model in mem_cp_model.sv and exec_params.svh on the path.
 */
`include "exec_params.svh"
module tb_swap_swi_coproc_data_exec;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, mem_rdata, cp_instr, wr_data, wr_addr;
   logic avs_waitrequest, mem_ready, mem_abort, cp_valid, cp_busy, irq_inhibit;
   exec_pkg::mem_req_type mem_req;
   logic [31:0] mem_init = 32'h0;
   logic [3:0] delay = 4'h0;
   logic [1:0] abort_mode = 2'h0;
   logic [7:0] busy_n = 8'h0;
   logic [7:0] acc_count, cp_count, lock_err;
   int errors = 0;
   int check_count = 0;

   swap_swi_coproc_data_exec u_dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
      .mem_rdata(mem_rdata), .mem_ready(mem_ready), .mem_abort(mem_abort), .cp_instr(cp_instr),
      .cp_valid(cp_valid), .cp_busy(cp_busy), .irq_inhibit(irq_inhibit));
   mem_cp_model u_model (.clk(clk), .rst_b(rst_b), .mem_req(mem_req), .mem_rdata(mem_rdata),
      .mem_ready(mem_ready), .mem_abort(mem_abort), .cp_valid(cp_valid), .cp_instr(cp_instr),
      .cp_busy(cp_busy), .irq_inhibit(irq_inhibit), .mem_init(mem_init), .delay(delay),
      .abort_mode(abort_mode), .busy_n(busy_n), .wr_data(wr_data), .wr_addr(wr_addr),
      .acc_count(acc_count), .cp_count(cp_count), .lock_err(lock_err));

   // 125 MHz
   always #4 clk = ~clk;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task report_and_stop;
      if (errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   task chk32(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk32

   // Request held until an edge samples waitrequest low; data taken there
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 500);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 500) begin
         errors++;
         report_and_stop();
      end
   endtask : bus

   task wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task rd(input logic [5:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask : rd

   task chk_reg(input logic [5:0] a, input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] q;
      rd(a, q);
      chk32(q & mask, exp);
   endtask : chk_reg

   // Issue and poll busy; a hung sequencer ends the run
   task issue(input logic [31:0] w);
      logic [31:0] s;
      int n;
      wr(`OFS_INSTR, w);
      n = 0;
      do begin
         rd(`OFS_EXEC_STATUS, s);
         n++;
      end while (s[0] !== 1'b0 && n < 100);
      if (n >= 100) begin
         errors++;
         report_and_stop();
      end
   endtask : issue

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      chk_reg(`OFS_STATUS_WORD, 32'hffffffff, 32'h13);
      chk_reg(`OFS_PC, 32'hffffffff, 32'h0);
      chk_reg(6'h3c, 32'hffffffff, 32'h0);
   endtask : t_reset

   task t_swap_word;
      logic [7:0] a0;
      a0 = acc_count;
      mem_init <= 32'h12345678;
      wr(`OFS_SWAP_BASE, 32'h100);
      wr(`OFS_SWAP_SOURCE, 32'ha5a55a5a);
      wr(`OFS_PC, 32'h80);
      issue(32'he1000090);
      chk_reg(`OFS_SWAP_RESULT, 32'hffffffff, 32'h12345678);
      chk32(wr_data, 32'ha5a55a5a);
      chk32(wr_addr, 32'h100);
      chk32({31'h0, mem_req.byte_sel}, 32'h0);
      chk32({24'h0, acc_count - a0}, 32'h2);
      chk32({24'h0, lock_err}, 32'h0);
      chk_reg(`OFS_PC, 32'hffffffff, 32'h84);
   endtask : t_swap_word

   // Slow memory, both lane orders
   task t_swap_byte;
      for (int e = 0; e < 2; e++) begin
         delay <= 4'h2;
         mem_init <= 32'h11223344;
         wr(`OFS_CONTROL, e);
         wr(`OFS_SWAP_BASE, 32'h101);
         wr(`OFS_SWAP_SOURCE, 32'h1234abcd);
         issue(32'he1400090);
         chk_reg(`OFS_SWAP_RESULT, 32'hffffffff, e ? 32'h22 : 32'h33);
         chk32(wr_data, 32'hcdcdcdcd);
         chk32({31'h0, mem_req.byte_sel}, 32'h1);
      end
      chk32({24'h0, lock_err}, 32'h0);
      delay <= 4'h0;
   endtask : t_swap_byte

   // Abort on read, on write, on both
   task t_abort;
      logic [31:0] r0;
      for (int m = 1; m < 4; m++) begin
         abort_mode <= m[1:0];
         wr(`OFS_STATUS_WORD, 32'h10);
         wr(`OFS_PC, 32'h40 * m);
         rd(`OFS_SWAP_RESULT, r0);
         issue(32'he1000090);
         chk_reg(`OFS_PC, 32'hffffffff, `ABORT_VECTOR);
         chk_reg(`OFS_STATUS_WORD, 32'h1f, {27'h0, `MODE_ABORT});
         chk_reg(`OFS_SAVED_STATUS, 32'hffffffff, 32'h10);
         chk_reg(`OFS_LINK, 32'hffffffff, 32'h40 * m + 32'h4);
         chk_reg(`OFS_EXEC_STATUS, 32'h2, 32'h2);
         chk_reg(`OFS_SWAP_RESULT, 32'hffffffff, r0);
         wr(`OFS_EXEC_STATUS, 32'h2);
         chk_reg(`OFS_EXEC_STATUS, 32'h2, 32'h0);
      end
      abort_mode <= 2'h0;
   endtask : t_abort

   task t_swi_return;
      wr(`OFS_STATUS_WORD, 32'h60000010);
      wr(`OFS_PC, 32'h200);
      issue(32'hef123456);
      chk_reg(`OFS_PC, 32'hffffffff, `SUPERVISOR_VECTOR);
      chk_reg(`OFS_SAVED_STATUS, 32'hffffffff, 32'h60000010);
      chk_reg(`OFS_STATUS_WORD, 32'hffffffff, 32'h60000013);
      chk_reg(`OFS_LINK, 32'hffffffff, 32'h204);
      issue(32'he1b0f00e);
      chk_reg(`OFS_PC, 32'hffffffff, 32'h204);
      chk_reg(`OFS_STATUS_WORD, 32'hffffffff, 32'h60000010);
   endtask : t_swi_return

   // Zero flag clear: equal fails, not-equal passes
   task t_cond;
      logic [7:0] a0;
      a0 = acc_count;
      wr(`OFS_STATUS_WORD, 32'h10);
      wr(`OFS_PC, 32'h300);
      issue(32'h01000090);
      chk_reg(`OFS_EXEC_STATUS, 32'h4, 32'h4);
      chk32({24'h0, acc_count}, {24'h0, a0});
      chk_reg(`OFS_PC, 32'hffffffff, 32'h304);
      issue(32'h1f000000);
      chk_reg(`OFS_PC, 32'hffffffff, `SUPERVISOR_VECTOR);
   endtask : t_cond

   task t_cdp;
      logic [7:0] c0;
      c0 = cp_count;
      busy_n <= 8'h3;
      wr(`OFS_PC, 32'h400);
      issue(32'hee1234e3);
      chk32(cp_instr, 32'hee1234e3);
      chk_reg(`OFS_EXEC_STATUS, 32'hff00, 32'h0300);
      chk32({24'h0, cp_count}, {24'h0, c0 + 8'h1});
      chk_reg(`OFS_PC, 32'hffffffff, 32'h404);
      // Unowned number: nobody answers busy, the processor still moves on
      issue(32'heeff0fe0);
      chk32(cp_instr, 32'heeff0fe0);
      chk_reg(`OFS_EXEC_STATUS, 32'hff00, 32'h0);
      chk32({24'h0, cp_count}, {24'h0, c0 + 8'h1});
      chk_reg(`OFS_PC, 32'hffffffff, 32'h408);
      issue(32'hee000010);
      chk32(cp_instr, 32'heeff0fe0);
   endtask : t_cdp

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      t_swap_word();
      t_swap_byte();
      t_abort();
      t_swi_return();
      t_cond();
      t_cdp();
      report_and_stop();
   end

   initial begin
      #720000;
      errors++;
      report_and_stop();
   end
endmodule : tb_swap_swi_coproc_data_exec
